// ===== core/ibc_consts.svh
// Constants of the two-wire bus control block: counts, codes and reset values.
`ifndef IBC_CONSTS_SVH
`define IBC_CONSTS_SVH
`define IBC_LAST_DATA 4'h7
`define IBC_ACK_SLOT 4'h8
`define IBC_NINTH 4'h9
`define IBC_TENTH 4'ha
`define IBC_SMD_DISABLED 3'h0
`define IBC_DLY_NONE 3'h0
`define IBC_DLY_TAPS 8
`define IBC_BAUD_RST 8'h00
`define IBC_RX_RST 9'h000
`define IBC_TX_RST 8'hff
`define IBC_DLY_RST 8'hff
`endif

// ===== core/ibc_core.sv
// Two-wire bus mode control: conditions, arbitration, clocking and data path.
// Behaviour
// (R1) Detect start and stop with clock high.
// (R2) Start and stop share one request line; the code has separate start, restart and stop request inputs.
// (R3) Software sets request, then condition select.
// (R4) Select picks port output or generated conditions.
// (R5) Per-bit mismatch flag on each clock rise.
// (R6) Per-byte mismatch set at ninth falling edge.
// (R7) Software clears per-byte flag between bytes.
// (R8) Mismatch with stop enable releases data line.
// (R9) Clock sync reloads counter, pauses while pin low.
// (R10) Transfer clock is internal AND pin clock.
// (R11) Wait select holds clock low after ninth.
// (R12) Stop detection releases clock when enabled.
// (R13) Forced-low select drives clock pin low.
// (R14) Tenth-pulse hold keeps clock low after tenth.
// (R15) Eight data bits MSB first, ninth acknowledge.
// (R16) Initial data level set while serial disabled.
// (R17) Data output delay none or two-eight cycles.
// (R18) Data-disable bit releases the data line.
// (R19) Receive layout select places received bits.
// (R20) Acknowledge output drives the acknowledge data bit.
// (R21) Ninth rise raises acknowledge or not-acknowledge.
// (R22) Start-init reloads shift registers and waits.
// (R23) Pin inputs synchronised before any edge logic.
`timescale 1ns/1ps
`default_nettype none
`include "ibc_consts.svh"
module ibc_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclPinIn,
  input wire logic sdaPinIn,
  output logic sclOut,
  output logic sclOeN,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic baudTick,
  input wire logic [7:0] baudCounterLoad,
  input wire logic internalClockSel,
  input wire logic busModeSelect,
  input wire logic [2:0] serialModeField,
  input wire logic sdaInitLevel,
  input wire logic [7:0] transmitBuffer,
  input wire logic transmitWrite,
  output logic transmitEmptyFlag,
  output logic [8:0] receiveBuffer,
  output logic receiveValid,
  input wire logic startRequest,
  input wire logic restartRequest,
  input wire logic stopRequest,
  input wire logic conditionOutputSelect,
  output logic conditionIrq,
  output logic busBusyFlag,
  input wire logic arbitrationUpdateSelect,
  output logic mismatchFlag,
  input wire logic mismatchClear,
  input wire logic dataOutputStopEnable,
  output logic arbitrationLost,
  input wire logic clockSyncEnable,
  input wire logic clockWaitSelect,
  input wire logic waitRelease,
  input wire logic stopReleaseEnable,
  input wire logic forcedLowSelect,
  input wire logic tenthPulseHoldEnable,
  input wire logic clockPhaseBit,
  input wire logic [2:0] dataDelayField,
  input wire logic dataDisableBit,
  input wire logic receiveLayoutSelect,
  input wire logic ackOutputEnable,
  input wire logic ackDataBit,
  output logic ackIrq,
  output logic nackIrq,
  output logic dmaAckRequest,
  input wire logic startInitEnable
);
  ibc_pkg::ibc_state_t r;
  ibc_pkg::ibc_state_t n;
  logic sclS;
  logic sdaS;
  logic xclk;
  logic xRise;
  logic xFall;
  logic startDet;
  logic stopDet;
  logic syncFall;
  logic pauseCnt;
  logic genTick;
  logic cmpFail;
  logic serialOff;
  logic waitEff;
  logic tenthMode;
  logic dlySda;
  logic [3:0] lastRise;

  // ********************************************************************
  // Pin synchronisation and edge detection
  // ********************************************************************

  // Both pins pass two flops before any comparator sees them. [R23]
  ibc_sync2 #(.W(2)) u_sync (
    .clk(clk),
    .reset(reset),
    .din({sclPinIn, sdaPinIn}),
    .dout({sclS, sdaS})
  );

  // Conditions are data-line edges while the clock line stays high.
  assign startDet = sclS && r.sclPrev && r.sdaPrev && !sdaS; // [R1]
  assign stopDet = sclS && r.sclPrev && !r.sdaPrev && sdaS; // [R1]
  // The transfer clock is the AND of the internal and pin clocks. [R10]
  assign xclk = (internalClockSel ? r.intScl : 1'b1) && sclS;
  assign xRise = xclk && !r.xclkPrev;
  assign xFall = !xclk && r.xclkPrev;
  // Sync only makes sense with the internal clock driving the bus.
  assign syncFall = clockSyncEnable && internalClockSel && r.xferActive
                    && r.intScl && r.sclPrev && !sclS; // [R9]
  assign pauseCnt = clockSyncEnable && internalClockSel && r.xferActive
                    && r.intScl && !sclS; // [R9]
  assign genTick = baudTick && (r.baudCnt == `IBC_BAUD_RST);
  // A mismatch is a driven level that the line does not show.
  assign cmpFail = (r.sdaBit != sdaS);
  assign serialOff = busModeSelect && (serialModeField == `IBC_SMD_DISABLED);
  assign waitEff = clockWaitSelect || r.initWait;
  assign tenthMode = clockPhaseBit && tenthPulseHoldEnable;
  assign lastRise = tenthMode ? `IBC_TENTH : `IBC_NINTH;

  // ********************************************************************
  // Data output delay
  // ********************************************************************

  // Delay only the data level so that releases still act at once. [R17]
  ibc_sda_delay u_delay (
    .clk(clk),
    .reset(reset),
    .baudTick(baudTick),
    .dataIn(r.sdaBit),
    .delaySel(dataDelayField),
    .dataOut(dlySda)
  );

  // Pin levels for each generated condition step, as {clock, data}.
  function automatic logic [1:0] genLevels(input ibc_pkg::ibc_cond_t kind,
                                           input ibc_pkg::ibc_gen_t step);
    logic [1:0] lv;
    lv = 2'h3;
    unique case (kind)
      ibc_pkg::CK_START: begin
        lv = (step == ibc_pkg::GEN_ONE) ? 2'h3 :
             (step == ibc_pkg::GEN_TWO) ? 2'h2 : 2'h0;
      end
      ibc_pkg::CK_RESTART: begin
        lv = (step == ibc_pkg::GEN_ONE) ? 2'h1 :
             (step == ibc_pkg::GEN_TWO) ? 2'h3 : 2'h2;
      end
      ibc_pkg::CK_STOP: begin
        lv = (step == ibc_pkg::GEN_ONE) ? 2'h0 :
             (step == ibc_pkg::GEN_TWO) ? 2'h2 : 2'h3;
      end
      default: begin
        lv = 2'h3;
      end
    endcase
    return lv;
  endfunction

  // ********************************************************************
  // Next-state logic
  // ********************************************************************

  // All state advances here; later sections override earlier ones.
  always_comb begin
    n = r;
    n.sclPrev = sclS;
    n.sdaPrev = sdaS;
    n.xclkPrev = xclk;
    n.condSelPrev = conditionOutputSelect;
    n.condIrq = 1'b0;
    n.ackIrq = 1'b0;
    n.nackIrq = 1'b0;
    n.rxValid = 1'b0;
    // Bus busy follows conditions; start, restart and stop each have their own request. [R2]
    if (startDet) begin
      n.busBusy = 1'b1;
      n.stopRel = 1'b0;
    end
    if (stopDet) begin
      n.busBusy = 1'b0;
      n.arbLost = 1'b0;
      n.stopRel = stopReleaseEnable; // [R12]
    end
    if ((startDet || stopDet) && !conditionOutputSelect) begin
      n.condIrq = 1'b1; // [R4]
    end
    // Baud counter: a sync fall reloads it for the low phase. [R9]
    if (syncFall) begin
      n.baudCnt = baudCounterLoad;
      n.intScl = 1'b0;
    end else if (baudTick && !pauseCnt) begin
      if (r.baudCnt == `IBC_BAUD_RST) begin
        n.baudCnt = baudCounterLoad;
        if (r.xferActive && r.bitCnt < lastRise) begin
          n.intScl = !r.intScl; // [R10]
        end
      end else begin
        n.baudCnt = r.baudCnt - 8'h01;
      end
    end
    if (!r.xferActive) begin
      n.intScl = 1'b1;
    end
    // Condition generator, armed by the select rising after a request. [R3]
    unique case (r.genState)
      ibc_pkg::GEN_IDLE: begin
        if (conditionOutputSelect && !r.condSelPrev
            && (startRequest || restartRequest || stopRequest)) begin
          n.genState = ibc_pkg::GEN_ONE;
          n.genKind = startRequest ? ibc_pkg::CK_START :
                      restartRequest ? ibc_pkg::CK_RESTART : ibc_pkg::CK_STOP;
        end
      end
      ibc_pkg::GEN_ONE: begin
        if (genTick) begin
          n.genState = ibc_pkg::GEN_TWO;
        end
      end
      ibc_pkg::GEN_TWO: begin
        if (genTick) begin
          n.genState = ibc_pkg::GEN_THREE;
        end
      end
      ibc_pkg::GEN_THREE: begin
        if (genTick) begin
          n.genState = ibc_pkg::GEN_IDLE;
          n.condIrq = 1'b1; // [R4]
        end
      end
    endcase
    if (r.genState != ibc_pkg::GEN_IDLE) begin
      {n.genScl, n.genSda} = genLevels(r.genKind, r.genState);
    end
    // Software clear goes first so a same-cycle set still wins.
    if (mismatchClear) begin
      n.mismatch = 1'b0;
    end
    if (!tenthPulseHoldEnable) begin
      n.tenthHold = 1'b0; // [R14]
    end
    if (waitRelease) begin
      n.initWait = 1'b0;
    end
    if (!(clockWaitSelect || n.initWait)) begin
      n.holdLow = 1'b0; // [R11]
    end
    // A loaded buffer starts the next byte when the channel is idle.
    if (!r.xferActive && !r.txEmpty && !serialOff) begin
      n.xferActive = 1'b1;
      n.txShift = transmitBuffer;
      n.bitCnt = 4'h0;
      n.mismatchAcc = 1'b0;
      n.txEmpty = 1'b1;
    end
    // Rising edges sample the line and check arbitration.
    if (xRise && r.xferActive) begin
      if (r.bitCnt <= `IBC_LAST_DATA) begin
        n.rxShift = {r.rxShift[6:0], sdaS};
        if (!arbitrationUpdateSelect) begin
          n.mismatch = cmpFail || (n.mismatch && !cmpFail && 1'b0); // [R5]
        end else begin
          n.mismatchAcc = r.mismatchAcc || cmpFail; // [R6]
        end
        if (r.bitCnt == `IBC_LAST_DATA && receiveLayoutSelect) begin
          n.rxBuf = {sdaS, 1'b0, r.rxShift[6:0]}; // [R19]
          n.rxValid = 1'b1;
        end
      end
      if (r.bitCnt == `IBC_ACK_SLOT) begin
        if (!receiveLayoutSelect) begin
          n.ackIrq = !sdaS; // [R21]
          n.nackIrq = sdaS; // [R21]
        end
        if (!receiveLayoutSelect || clockPhaseBit) begin
          n.rxBuf = {sdaS, r.rxShift}; // [R19]
          n.rxValid = 1'b1;
        end
      end
      if (r.bitCnt < `IBC_TENTH) begin
        n.bitCnt = r.bitCnt + 4'h1;
      end
    end
    // Falling edges move the next output bit onto the line.
    if (xFall && r.xferActive) begin
      if (r.bitCnt <= `IBC_LAST_DATA) begin
        n.sdaBit = r.txShift[7]; // [R15]
        n.txShift = {r.txShift[6:0], 1'b1};
      end else if (r.bitCnt == `IBC_ACK_SLOT) begin
        n.sdaBit = (ackOutputEnable && !conditionOutputSelect) ? ackDataBit
                   : 1'b1; // [R20]
      end else if (r.bitCnt == `IBC_NINTH) begin
        n.sdaBit = 1'b1;
        n.holdLow = waitEff; // [R11]
        if (arbitrationUpdateSelect && r.mismatchAcc) begin
          n.mismatch = 1'b1; // [R6]
        end
        n.xferActive = tenthMode;
      end else begin
        n.tenthHold = tenthMode; // [R14]
        n.xferActive = 1'b0;
      end
    end
    // A detected start can restart both shift registers in place. [R22]
    if (startDet && startInitEnable) begin
      n.xferActive = 1'b1;
      n.txShift = transmitBuffer;
      n.rxShift = 8'h00;
      n.bitCnt = 4'h0;
      n.mismatchAcc = 1'b0;
      n.initWait = 1'b1;
      n.txEmpty = r.txEmpty;
    end
    // With serial disabled the initial data level may be set. [R16]
    if (serialOff) begin
      n.xferActive = 1'b0;
      n.sdaBit = sdaInitLevel;
    end
    if (transmitWrite) begin
      n.txEmpty = 1'b0;
    end
    if (dataOutputStopEnable && n.mismatch) begin
      n.arbLost = 1'b1; // [R8]
    end
    // Pin enables follow the state just computed, so a loss releases at once.
    // The disable bit wins over generated conditions as well as transfer data.
    n.sdaOeN = dataDisableBit || (conditionOutputSelect ? n.genSda
               : (n.arbLost || dlySda)); // [R8] [R18]
    n.sclOeN = !(forcedLowSelect || (!n.stopRel && (n.holdLow || n.tenthHold
               || (conditionOutputSelect ? !n.genScl
               : (internalClockSel && n.xferActive && !n.intScl))))); // [R13]
  end

  // ********************************************************************
  // State register
  // ********************************************************************

  // Every field starts idle with both pins released.
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.sclPrev <= 1'b1;
      r.sdaPrev <= 1'b1;
      r.xclkPrev <= 1'b1;
      r.genScl <= 1'b1;
      r.genSda <= 1'b1;
      r.intScl <= 1'b1;
      r.txShift <= `IBC_TX_RST;
      r.rxBuf <= `IBC_RX_RST;
      r.sdaBit <= 1'b1;
      r.txEmpty <= 1'b1;
      r.sclOeN <= 1'b1;
      r.sdaOeN <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Open-drain pins only ever pull low; the enables carry the level.
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOeN = r.sclOeN;
  assign sdaOeN = r.sdaOeN;
  assign transmitEmptyFlag = r.txEmpty;
  assign receiveBuffer = r.rxBuf;
  assign receiveValid = r.rxValid;
  assign conditionIrq = r.condIrq;
  assign busBusyFlag = r.busBusy;
  assign mismatchFlag = r.mismatch;
  assign arbitrationLost = r.arbLost;
  assign ackIrq = r.ackIrq;
  assign nackIrq = r.nackIrq;
  assign dmaAckRequest = r.ackIrq; // [R21]

  // ********************************************************************
  // Assertions
  // ********************************************************************

  sequence s_ninthFall;
    xFall && r.xferActive && (r.bitCnt == `IBC_NINTH);
  endsequence

  sequence s_dataRise;
    xRise && r.xferActive && (r.bitCnt <= `IBC_LAST_DATA);
  endsequence

  a_start_detect: assert property (@(posedge clk) disable iff (reset) // [R1]
    startDet && !conditionOutputSelect |=> conditionIrq && busBusyFlag)
    else $error("start not reported");
  a_stop_detect: assert property (@(posedge clk) disable iff (reset) // [R1]
    stopDet |=> !busBusyFlag ##0 (conditionIrq || $past(conditionOutputSelect)))
    else $error("stop not reported");
  a_bit_mismatch: assert property (@(posedge clk) disable iff (reset) // [R5]
    s_dataRise ##0 (!arbitrationUpdateSelect && !mismatchClear)
    |=> mismatchFlag == $past(cmpFail))
    else $error("per-bit mismatch wrong");
  a_byte_mismatch: assert property (@(posedge clk) disable iff (reset) // [R6]
    s_ninthFall ##0 (arbitrationUpdateSelect && r.mismatchAcc) |=> mismatchFlag)
    else $error("per-byte mismatch missing");
  a_loss_release: assert property (@(posedge clk) disable iff (reset) // [R8]
    mismatchFlag && dataOutputStopEnable && !conditionOutputSelect
    |-> arbitrationLost && sdaOeN)
    else $error("data not released on loss");
  a_forced_low: assert property (@(posedge clk) disable iff (reset) // [R13]
    forcedLowSelect |=> !sclOeN)
    else $error("clock not forced low");
  a_wait_hold: assert property (@(posedge clk) disable iff (reset) // [R11]
    s_ninthFall ##0 (clockWaitSelect && !forcedLowSelect && !r.stopRel)
    |=> !sclOeN [*2] or ($past(stopDet) || !clockWaitSelect))
    else $error("clock wait not held");
  a_disable_data: assert property (@(posedge clk) disable iff (reset) // [R18]
    dataDisableBit |=> sdaOeN)
    else $error("data disable ignored");
  a_ack_pulse: assert property (@(posedge clk) disable iff (reset) // [R21]
    xRise && r.xferActive && r.bitCnt == `IBC_ACK_SLOT && !receiveLayoutSelect
    |=> (ackIrq != nackIrq) ##1 (!ackIrq && !nackIrq))
    else $error("acknowledge pulse wrong");
  a_init_load: assert property (@(posedge clk) disable iff (reset) // [R22]
    startDet && startInitEnable && !serialOff
    |=> r.xferActive && r.bitCnt == 4'h0 && r.sdaBit == $past(r.sdaBit))
    else $error("start init not applied");
endmodule
`default_nettype wire

// ===== core/ibc_pkg.sv
// Types shared by the two-wire bus control block.
package ibc_pkg;
  typedef enum logic [1:0] {
    GEN_IDLE = 2'h0,
    GEN_ONE = 2'h1,
    GEN_TWO = 2'h3,
    GEN_THREE = 2'h2
  } ibc_gen_t;
  typedef enum logic [1:0] {
    CK_START = 2'h0,
    CK_RESTART = 2'h1,
    CK_STOP = 2'h2
  } ibc_cond_t;
  typedef struct packed {
    logic [7:0] taps;
  } ibc_dly_t;
  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
    logic xclkPrev;
    logic condSelPrev;
    logic busBusy;
    ibc_gen_t genState;
    ibc_cond_t genKind;
    logic genScl;
    logic genSda;
    logic condIrq;
    logic intScl;
    logic [7:0] baudCnt;
    logic xferActive;
    logic [3:0] bitCnt;
    logic [7:0] txShift;
    logic sdaBit;
    logic [7:0] rxShift;
    logic [8:0] rxBuf;
    logic rxValid;
    logic mismatch;
    logic mismatchAcc;
    logic arbLost;
    logic holdLow;
    logic initWait;
    logic stopRel;
    logic tenthHold;
    logic ackIrq;
    logic nackIrq;
    logic txEmpty;
    logic sclOeN;
    logic sdaOeN;
  } ibc_state_t;
endpackage

// ===== core/ibc_sda_delay.sv
// Data-line output delay of zero or two to eight count-source cycles.
`timescale 1ns/1ps
`default_nettype none
`include "ibc_consts.svh"
module ibc_sda_delay (
  input wire logic clk,
  input wire logic reset,
  input wire logic baudTick,
  input wire logic dataIn,
  input wire logic [2:0] delaySel,
  output logic dataOut
);
  ibc_pkg::ibc_dly_t r;
  ibc_pkg::ibc_dly_t n;

  // Each count-source cycle pushes the level one tap further.
  always_comb begin
    n = r;
    if (baudTick) begin
      n.taps = {r.taps[`IBC_DLY_TAPS-2:0], dataIn};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r.taps <= `IBC_DLY_RST;
    end else begin
      r <= n;
    end
  end

  // Code one gives two cycles, so the tap index equals the code.
  assign dataOut = (delaySel == `IBC_DLY_NONE) ? dataIn : r.taps[delaySel];
endmodule
`default_nettype wire

// ===== core/ibc_sync2.sv
// Two-stage synchroniser for levels that arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module ibc_sync2 #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  // The first stage feeds only the second; both idle high like a released bus.
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_r <= '1;
      stage2_r <= '1;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;
endmodule
`default_nettype wire

// ===== verif/ibc_bus_peer.sv
// Far-side bus master model that drives the open-drain clock and data lines.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-side master
// ****************************************
module ibc_bus_peer (
  output var logic sclRel,
  output var logic sdaRel
);
  // Both lines rest released; the bench's pull-up makes them read high.
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  // Start: data falls while the clock is high, then the clock falls.
  task automatic putStart();
    sdaRel = 1'b0;
    #120;
    sclRel = 1'b0;
  endtask
  // Nine pulses, 200 ns low and 120 ns high; data moves only while the clock is low.
  task automatic putByte(input logic [8:0] bits);
    for (int i = 8; i >= 0; i--) begin
      #40 sdaRel = bits[i];
      #160 sclRel = 1'b1;
      #120 sclRel = 1'b0;
    end
  endtask
  // Stop: data rises while the clock is high, then the bus rests idle.
  task automatic putStop();
    #40 sdaRel = 1'b0;
    #160 sclRel = 1'b1;
    #120 sdaRel = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// ===== verif/test_ibc_core.sv
// Self-checking bench: generated and detected conditions, slave bytes, clock holds.
`timescale 1ns/1ps
`default_nettype none
`define IBC_CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ibc_core;
  logic clk, reset, baudTick, sclRel, sdaRel, sclOut, sclOeN, sdaOut, sdaOeN;
  logic busModeSelect, sdaInitLevel, transmitWrite, transmitEmptyFlag, receiveValid;
  logic startRequest, restartRequest, stopRequest, conditionOutputSelect, conditionIrq;
  logic busBusyFlag, arbitrationUpdateSelect, mismatchFlag, mismatchClear, arbitrationLost;
  logic dataOutputStopEnable, clockSyncEnable, clockWaitSelect, waitRelease, forcedLowSelect;
  logic clockPhaseBit, dataDisableBit, receiveLayoutSelect, ackOutputEnable, ackDataBit;
  logic ackIrq, nackIrq, dmaAckRequest;
  logic [2:0] serialModeField;
  logic [7:0] transmitBuffer, tx, pb;
  logic [8:0] receiveBuffer;
  logic lay, ph, cws, ackEn, ack_data_bit, mm, a9, aus, si, startInitEnable;
  int mismatches, check_count, condCnt, ackCnt, nackCnt, rvCnt, c, a0, n0, r0, seed;
  // Open-drain lines with pull-ups: low when either party pulls low.
  wire sclLine = sclRel & (sclOeN | sclOut);
  wire sdaLine = sdaRel & (sdaOeN | sdaOut);
  ibc_bus_peer ibc_bus_peer_inst (.sclRel(sclRel), .sdaRel(sdaRel));
  ibc_core ibc_core_inst (.clk(clk), .reset(reset), .sclPinIn(sclLine), .sdaPinIn(sdaLine),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .baudTick(baudTick),
    .baudCounterLoad(8'h02), .internalClockSel(1'b0), .busModeSelect(busModeSelect),
    .serialModeField(serialModeField), .sdaInitLevel(sdaInitLevel),
    .transmitBuffer(transmitBuffer), .transmitWrite(transmitWrite),
    .transmitEmptyFlag(transmitEmptyFlag), .receiveBuffer(receiveBuffer),
    .receiveValid(receiveValid), .startRequest(startRequest), .restartRequest(restartRequest),
    .stopRequest(stopRequest), .conditionOutputSelect(conditionOutputSelect),
    .conditionIrq(conditionIrq), .busBusyFlag(busBusyFlag),
    .arbitrationUpdateSelect(arbitrationUpdateSelect), .mismatchFlag(mismatchFlag),
    .mismatchClear(mismatchClear), .dataOutputStopEnable(dataOutputStopEnable),
    .arbitrationLost(arbitrationLost), .clockSyncEnable(clockSyncEnable),
    .clockWaitSelect(clockWaitSelect), .waitRelease(waitRelease),
    .stopReleaseEnable(1'b0), .forcedLowSelect(forcedLowSelect),
    .tenthPulseHoldEnable(1'b0), .clockPhaseBit(clockPhaseBit), .dataDelayField(3'h0),
    .dataDisableBit(dataDisableBit), .receiveLayoutSelect(receiveLayoutSelect),
    .ackOutputEnable(ackOutputEnable), .ackDataBit(ackDataBit), .ackIrq(ackIrq),
    .nackIrq(nackIrq), .dmaAckRequest(dmaAckRequest), .startInitEnable(startInitEnable));
  // ****************************************
  // Clock, count source and event counters
  // ****************************************
  // The clock toggles every 20 ns, a period of 40 ns.
  always #20 clk = ~clk;
  // The count source ticks every second cycle, driven off the sampling edge.
  always @(negedge clk) baudTick <= ~baudTick;
  // One-cycle pulses are counted at the edge where they stand.
  always @(posedge clk) begin
    if (conditionIrq === 1'b1) condCnt++;
    if (ackIrq === 1'b1) ackCnt++;
    if (nackIrq === 1'b1) nackCnt++;
    if (receiveValid === 1'b1) rvCnt++;
    if (!reset && (ackIrq | dmaAckRequest)) `IBC_CHK(dmaAckRequest, ackIrq)
  end
  // Expected receive word: layout 1 keeps the split form unless the phase bit rewrites it.
  function automatic logic [8:0] expRx(logic [7:0] ln, logic b9, logic ly, logic p);
    if (!ly || p) return {b9, ln};
    return {ln[0], 1'b0, ln[7:1]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // A condition interrupt must follow within a bounded number of cycles.
  task automatic waitCond(input int c0);
    for (int n = 0; n < 600; n++) begin
      @(negedge clk);
      if (condCnt > c0) return;
    end
    mismatches++;
    close_out();
  endtask
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {clk, baudTick, transmitWrite, startRequest, restartRequest, stopRequest} = '0;
    {conditionOutputSelect, mismatchClear, dataOutputStopEnable, clockSyncEnable} = '0;
    {clockWaitSelect, waitRelease, forcedLowSelect, clockPhaseBit, dataDisableBit} = '0;
    {receiveLayoutSelect, ackOutputEnable, ackDataBit, arbitrationUpdateSelect} = '0;
    {mismatches, check_count, condCnt, ackCnt, nackCnt, rvCnt} = '0;
    startInitEnable = 1'b0;
    reset = 1'b1;
    busModeSelect = 1'b1;
    serialModeField = 3'h0;
    sdaInitLevel = 1'b1;
    transmitBuffer = 8'hff;
    seed = $urandom(32'hf63e);
    cyc(20);
    reset = 1'b0;
    cyc(2);
    `IBC_CHK({sclOeN, sdaOeN, transmitEmptyFlag, busBusyFlag}, 4'he)
    `IBC_CHK({receiveBuffer, mismatchFlag}, 10'h000)
    serialModeField = 3'h2;
    // Generated start: request first, then the select rises.
    startRequest = 1'b1;
    cyc(1);
    conditionOutputSelect = 1'b1;
    waitCond(condCnt);
    cyc(4);
    `IBC_CHK({sclOeN, sdaOeN, busBusyFlag}, 3'h1)
    dataDisableBit = 1'b1;
    cyc(3);
    `IBC_CHK(sdaOeN, 1'b1)
    dataDisableBit = 1'b0;
    // Generated stop needs the select to fall and rise again.
    conditionOutputSelect = 1'b0;
    startRequest = 1'b0;
    stopRequest = 1'b1;
    cyc(1);
    c = condCnt;
    conditionOutputSelect = 1'b1;
    waitCond(c);
    cyc(4);
    `IBC_CHK({sclOeN, sdaOeN, busBusyFlag}, 3'h6)
    conditionOutputSelect = 1'b0;
    stopRequest = 1'b0;
    cyc(20);
    // Slave bytes clocked by the far side; both parties drive data, so the line is the AND.
    for (int k = 0; k < 8; k++) begin
      tx = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      pb = (k == 0) ? 8'hff : (k == 1) ? 8'h5a : 8'($urandom);
      {lay, ph, cws, ackEn, ack_data_bit, aus, si} = 7'($urandom);
      mm = |(tx & ~pb);
      a9 = ackEn ? ack_data_bit : 1'b1;
      transmitBuffer = tx;
      {receiveLayoutSelect, clockPhaseBit, clockWaitSelect} = {lay, ph, cws};
      {ackOutputEnable, ackDataBit, arbitrationUpdateSelect} = {ackEn, ack_data_bit, aus};
      startInitEnable = si;
      dataOutputStopEnable = ~mm & 1'($urandom);
      {clockSyncEnable, waitRelease} = 2'($urandom);
      transmitWrite = 1'b1;
      cyc(1);
      {transmitWrite, waitRelease} = 2'h0;
      cyc(2);
      {c, a0, n0, r0} = {condCnt, ackCnt, nackCnt, rvCnt};
      ibc_bus_peer_inst.putStart();
      waitCond(c);
      `IBC_CHK(busBusyFlag, 1'b1)
      ibc_bus_peer_inst.putByte({pb, a9});
      cyc(8);
      `IBC_CHK(receiveBuffer, expRx(tx & pb, a9, lay, ph))
      // Per bit, the flag shows only the last data bit's compare.
      `IBC_CHK(mismatchFlag, aus ? mm : tx[0] & ~pb[0])
      `IBC_CHK(rvCnt - r0, (lay && ph) ? 2 : 1)
      `IBC_CHK(4'(ackCnt - a0), 4'(!lay && !a9))
      `IBC_CHK(4'(nackCnt - n0), 4'(!lay && a9))
      `IBC_CHK(sclOeN, ~(cws | si))
      {clockWaitSelect, waitRelease} = 2'h1;
      mismatchClear = 1'b1;
      cyc(1);
      {mismatchClear, waitRelease} = 2'h0;
      cyc(3);
      `IBC_CHK({sclOeN, mismatchFlag}, 2'h2)
      c = condCnt;
      ibc_bus_peer_inst.putStop();
      waitCond(c);
      `IBC_CHK(busBusyFlag, 1'b0)
    end
    forcedLowSelect = 1'b1;
    cyc(4);
    `IBC_CHK(sclOeN, 1'b0)
    forcedLowSelect = 1'b0;
    cyc(4);
    close_out();
  end
endmodule
`default_nettype wire
